//--- sbd_defs.vh
// constants for the serial bootstrap download block
`ifndef SBD_DEFS_VH
`define SBD_DEFS_VH

`define SBD_CLK_HZ          20000000
`define SBD_BAUD_7812       7812
`define SBD_BAUD_1200       1200
`define SBD_BAUD_9600       9600
`define SBD_BAUD_5208       5208
`define SBD_BAUD_3906       3906
`define SBD_CYC_7812        (`SBD_CLK_HZ / `SBD_BAUD_7812)
`define SBD_CYC_1200        (`SBD_CLK_HZ / `SBD_BAUD_1200)
`define SBD_CYC_9600        (`SBD_CLK_HZ / `SBD_BAUD_9600)
`define SBD_CYC_5208        (`SBD_CLK_HZ / `SBD_BAUD_5208)
`define SBD_CYC_3906        (`SBD_CLK_HZ / `SBD_BAUD_3906)

// idle timeouts in tenths of a character; one character is ten bit times
`define SBD_TMO_7812        8'h28
`define SBD_TMO_1200        8'h28
`define SBD_TMO_9600        8'h31
`define SBD_TMO_5208        8'hAD
`define SBD_TMO_3906        8'h82

// first character as seen while still listening at the default rate
`define SBD_SYNC_FAST       8'hFF
`define SBD_SYNC_SLOW_SEEN  8'hC0
`define SBD_SYNC_9600       8'hF0
`define SBD_SYNC_5208       8'hFD
`define SBD_SYNC_3906_SEEN  8'hE6
`define SBD_SKIP_CHAR       8'h00

`define SBD_RATE_7812       3'h0
`define SBD_RATE_1200       3'h1
`define SBD_RATE_9600       3'h2
`define SBD_RATE_5208       3'h3
`define SBD_RATE_3906       3'h4

`define SBD_RAM_DEPTH       512
`define SBD_RAM_FULL        10'h200
`define SBD_BOOT_ROM_LO     16'hBF40
`define SBD_BOOT_EN_RESET   1'b1

`endif

//--- sbd_host_model.sv
// host side model: sends download characters and collects echoes
`default_nettype none
module sbd_host_model (
  input  wire logic clk,
  input  wire logic txd_in,
  output var  logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cyc;
  logic [7:0] echo_q[$];
  initial begin
    rxd_out = 1'b1;
    cyc = 16;
  end
  // characters go back to back so the idle timer never fires mid-download
  task automatic send(input logic [7:0] b, input int bc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #2 rxd_out = fr[i];
      repeat (bc - 1) @(posedge clk);
    end
  endtask
  always begin
    logic [7:0] r;
    @(negedge txd_in);
    repeat (cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(posedge clk);
      r[i] = txd_in;
    end
    repeat (cyc) @(posedge clk);
    echo_q.push_back(r);
  end
endmodule
`default_nettype wire

//--- sbd_loader.v
// bootstrap serial loader: autobaud, RAM download with echo, idle end, boot ROM map
`include "sbd_defs.vh"
`default_nettype none
module sbd_loader #(
  parameter integer BIT_CYC_7812 = `SBD_CYC_7812,
  parameter integer BIT_CYC_1200 = `SBD_CYC_1200,
  parameter integer BIT_CYC_9600 = `SBD_CYC_9600,
  parameter integer BIT_CYC_5208 = `SBD_CYC_5208,
  parameter integer BIT_CYC_3906 = `SBD_CYC_3906
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire        MODA,
  input  wire        MODB,
  input  wire        RXD,
  input  wire        EXT_RATES,
  input  wire        BOOT_EN_CLR,
  input  wire [15:0] BUS_ADDR,
  input  wire [7:0]  USER_ROM_DATA,
  input  wire [7:0]  BOOT_ROM_DATA,
  input  wire [8:0]  RAM_RD_ADDR,
  input  wire        EMU_OE_N_PIN,
  input  wire [7:0]  EMU_ROM_DATA,
  output wire        TXD,
  output reg  [7:0]  READ_DATA,
  output wire        BOOT_ROM_ENABLE,
  output reg  [7:0]  RAM_RD_DATA,
  output wire        JUMP_RAM,
  output wire        JUMP_EEPROM,
  output wire        LOADING,
  output wire [9:0]  LOAD_COUNT,
  output wire        EPROM_EMUL,
  output wire [7:0]  EMU_DATA_OUT,
  output wire        EMU_DATA_OE_N
);
  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_RAMJ = 2'h2;
  localparam [1:0] ST_EEJ  = 2'h3;

  reg  [1:0]  rst_sync_ff;
  wire        rst_n_i = rst_sync_ff[1];
  reg  [5:0]  mode_sync_ff;
  reg  [1:0]  strap_cnt_ff;
  reg         strap_done_ff;
  reg         boot_mode_ff;
  reg         boot_en_ff;
  reg  [1:0]  state_ff;
  reg  [2:0]  rate_ff;
  reg  [7:0]  idle_ff;
  reg  [9:0]  count_ff;
  reg  [7:0]  ram [0:`SBD_RAM_DEPTH-1];
  reg  [15:0] bit_cyc;
  reg  [7:0]  tmo;
  reg  [3:0]  nxt_rate;
  wire [7:0]  rx_data;
  wire        rx_valid;
  wire        rx_busy;
  wire        bit_tick;
  wire        tx_valid;

  // {valid, rate}; the 1200 and 3906 rates are recognised from how their sync char looks at the default rate
  function [3:0] sync_rate;
    input [7:0] ch;
    input       ext;
    begin
      case (ch)
        `SBD_SYNC_FAST:      sync_rate = {1'b1, `SBD_RATE_7812};
        `SBD_SYNC_SLOW_SEEN: sync_rate = {1'b1, `SBD_RATE_1200};
        `SBD_SYNC_9600:      sync_rate = {ext, `SBD_RATE_9600};
        `SBD_SYNC_5208:      sync_rate = {ext, `SBD_RATE_5208};
        `SBD_SYNC_3906_SEEN: sync_rate = {ext, `SBD_RATE_3906};
        default:             sync_rate = 4'h0;
      endcase
    end
  endfunction

  function in_boot_rom;
    input [15:0] a;
    begin
      in_boot_rom = (a >= `SBD_BOOT_ROM_LO);
    end
  endfunction

  always @* begin
    case (rate_ff)
      `SBD_RATE_1200: begin bit_cyc = BIT_CYC_1200[15:0]; tmo = `SBD_TMO_1200; end
      `SBD_RATE_9600: begin bit_cyc = BIT_CYC_9600[15:0]; tmo = `SBD_TMO_9600; end
      `SBD_RATE_5208: begin bit_cyc = BIT_CYC_5208[15:0]; tmo = `SBD_TMO_5208; end
      `SBD_RATE_3906: begin bit_cyc = BIT_CYC_3906[15:0]; tmo = `SBD_TMO_3906; end
      default:        begin bit_cyc = BIT_CYC_7812[15:0]; tmo = `SBD_TMO_7812; end
    endcase
    nxt_rate = sync_rate(rx_data, EXT_RATES);
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // mode straps caught after release, once the synchroniser has filled
  always @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_sync_ff  <= 6'h3F;
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      boot_mode_ff  <= 1'b0;
      boot_en_ff    <= `SBD_BOOT_EN_RESET;
    end else if (CE) begin
      mode_sync_ff <= {mode_sync_ff[3:0], MODB, MODA};
      if (!strap_done_ff) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
        if (strap_cnt_ff == 2'h3 && mode_sync_ff[3:2] == mode_sync_ff[5:4]) begin
          strap_done_ff <= 1'b1;
          boot_mode_ff  <= (mode_sync_ff[5:4] == 2'h0);
          boot_en_ff    <= (mode_sync_ff[5:4] == 2'h0);
        end
      end else if (BOOT_EN_CLR && boot_mode_ff)
        boot_en_ff <= 1'b0;
    end
  end

  assign BOOT_ROM_ENABLE = boot_en_ff;

  always @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i)
      READ_DATA <= 8'h00;
    else if (CE)
      READ_DATA <= (boot_en_ff && in_boot_rom(BUS_ADDR)) ? BOOT_ROM_DATA : USER_ROM_DATA;
  end

  // emulation follows the raw pins: it has to hold while the core itself is in reset
  assign EPROM_EMUL    = ~RST_N & ~MODA & ~MODB;
  assign EMU_DATA_OE_N = ~(EPROM_EMUL & ~EMU_OE_N_PIN);
  assign EMU_DATA_OUT  = EMU_ROM_DATA;

  always @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_WAIT;
      rate_ff  <= `SBD_RATE_7812;
      idle_ff  <= 8'h00;
      count_ff <= 10'h000;
    end else if (CE) begin
      case (state_ff)
        ST_WAIT: begin
          // no timeout here; a stray char other than sync or skip is ignored
          if (boot_mode_ff && rx_valid) begin
            if (rx_data == `SBD_SKIP_CHAR)
              state_ff <= ST_EEJ;
            else if (nxt_rate[3]) begin
              rate_ff  <= nxt_rate[2:0];
              idle_ff  <= 8'h00;
              state_ff <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (rx_valid) begin
            idle_ff  <= 8'h00;
            count_ff <= count_ff + 10'h001;
            if (count_ff + 10'h001 == `SBD_RAM_FULL)
              state_ff <= ST_RAMJ;
          end else if (rx_busy) begin
            idle_ff <= 8'h00;
          end else if (bit_tick) begin
            // one tick beyond the limit: the first tick may land early in a bit
            if (idle_ff == tmo)
              state_ff <= ST_RAMJ;
            else
              idle_ff <= idle_ff + 8'h01;
          end
        end
        ST_RAMJ: state_ff <= ST_RAMJ;
        ST_EEJ:  state_ff <= ST_EEJ;
        default: state_ff <= ST_WAIT;
      endcase
    end
  end

  always @(posedge CLOCK) begin
    if (CE && state_ff == ST_LOAD && rx_valid)
      ram[count_ff[8:0]] <= rx_data;
  end

  always @(posedge CLOCK or negedge rst_n_i) begin
    if (!rst_n_i)
      RAM_RD_DATA <= 8'h00;
    else if (CE)
      RAM_RD_DATA <= ram[RAM_RD_ADDR];
  end

  assign tx_valid    = (state_ff == ST_LOAD) && rx_valid;
  assign JUMP_RAM    = (state_ff == ST_RAMJ);
  assign JUMP_EEPROM = (state_ff == ST_EEJ);
  assign LOADING     = (state_ff == ST_LOAD);
  assign LOAD_COUNT  = count_ff;

  sbd_uart u_uart (
    .clk         (CLOCK),
    .rst_n       (rst_n_i),
    .ce          (CE),
    .bit_cyc     (bit_cyc),
    .rxd_pin     (RXD),
    .tx_data     (rx_data),
    .tx_valid    (tx_valid),
    .tx_ready    (),
    .txd         (TXD),
    .rx_data_ff  (rx_data),
    .rx_valid_ff (rx_valid),
    .rx_busy     (rx_busy),
    .bit_tick_ff (bit_tick)
  );
endmodule
`default_nettype wire

//--- sbd_loader_props.sv
// concurrent checks on the bootstrap loader top ports
`default_nettype none
module sbd_loader_props #(
  parameter integer BIT_CYC_9600 = 13
) (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        MODA,
  input wire logic        MODB,
  input wire logic        EMU_OE_N_PIN,
  input wire logic        RXD,
  input wire logic        BOOT_EN_CLR,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0]  USER_ROM_DATA,
  input wire logic [7:0]  BOOT_ROM_DATA,
  input wire logic [7:0]  READ_DATA,
  input wire logic        BOOT_ROM_ENABLE,
  input wire logic        JUMP_RAM,
  input wire logic        JUMP_EEPROM,
  input wire logic        LOADING,
  input wire logic [9:0]  LOAD_COUNT,
  input wire logic        EPROM_EMUL,
  input wire logic        EMU_DATA_OE_N
);
  logic [4:0]  age_ff;
  logic [15:0] idle_ff;
  // age masks the two-flop reset release and the strap capture
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      age_ff <= 5'h00;
      idle_ff <= 16'h0000;
    end else begin
      if (age_ff != 5'h1F)
        age_ff <= age_ff + 5'h01;
      if (!RXD)
        idle_ff <= 16'h0000;
      else if (idle_ff != 16'hFFFF)
        idle_ff <= idle_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_boot_read;
    CE && BOOT_ROM_ENABLE && (BUS_ADDR >= 16'hBF40) && (age_ff > 5'h03);
  endsequence
  sequence s_user_read;
    CE && (!BOOT_ROM_ENABLE || BUS_ADDR < 16'hBF40) && (age_ff > 5'h03);
  endsequence
  sequence s_clr_req;
    CE && BOOT_EN_CLR && BOOT_ROM_ENABLE && (age_ff > 5'h18);
  endsequence
  property p_boot_read; s_boot_read |=> READ_DATA == $past(BOOT_ROM_DATA); endproperty
  property p_user_read; s_user_read |=> READ_DATA == $past(USER_ROM_DATA); endproperty
  property p_clr; s_clr_req |=> !BOOT_ROM_ENABLE; endproperty
  property p_sticky; !BOOT_ROM_ENABLE && (age_ff > 5'h18) |=> !BOOT_ROM_ENABLE; endproperty
  // checked through reset too: emulation only exists while the core is held
  property p_emul_off;
    disable iff (1'b0)
    EPROM_EMUL == (!RST_N && !MODA && !MODB) &&
    EMU_DATA_OE_N == !(!RST_N && !MODA && !MODB && !EMU_OE_N_PIN);
  endproperty
  property p_jump_end; JUMP_RAM |=> JUMP_RAM && !LOADING; endproperty
  property p_idle_end; $rose(JUMP_RAM) && LOAD_COUNT != 10'h200 |-> idle_ff >= 16'(40 * BIT_CYC_9600); endproperty
  property p_count; LOAD_COUNT != $past(LOAD_COUNT) |-> LOAD_COUNT == $past(LOAD_COUNT) + 10'h001; endproperty
  property p_excl; !(JUMP_RAM && JUMP_EEPROM); endproperty
  property p_armed; $rose(LOADING) |-> LOAD_COUNT == 10'h000 && !JUMP_RAM; endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot data not returned");
  a_user_read: assert property (p_user_read) else $error("user data not returned");
  a_clr: assert property (p_clr) else $error("boot enable did not clear");
  a_sticky: assert property (p_sticky) else $error("boot enable came back");
  a_emul_off: assert property (p_emul_off) else $error("emulation pins wrong");
  a_jump_end: assert property (p_jump_end) else $error("jump to ram not terminal");
  a_idle_end: assert property (p_idle_end) else $error("download ended too early");
  a_count: assert property (p_count) else $error("load count skipped");
  a_excl: assert property (p_excl) else $error("both jumps taken");
  a_armed: assert property (p_armed) else $error("loading began dirty");
endmodule
bind sbd_loader sbd_loader_props #(.BIT_CYC_9600(BIT_CYC_9600)) sbd_loader_props_inst (
  .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .RXD(RXD), .BOOT_EN_CLR(BOOT_EN_CLR),
  .MODA(MODA), .MODB(MODB), .EMU_OE_N_PIN(EMU_OE_N_PIN),
  .BUS_ADDR(BUS_ADDR), .USER_ROM_DATA(USER_ROM_DATA), .BOOT_ROM_DATA(BOOT_ROM_DATA),
  .READ_DATA(READ_DATA), .BOOT_ROM_ENABLE(BOOT_ROM_ENABLE), .JUMP_RAM(JUMP_RAM),
  .JUMP_EEPROM(JUMP_EEPROM), .LOADING(LOADING), .LOAD_COUNT(LOAD_COUNT),
  .EPROM_EMUL(EPROM_EMUL), .EMU_DATA_OE_N(EMU_DATA_OE_N));
`default_nettype wire

//--- sbd_loader_tb.sv
// self-checking bench for the serial bootstrap loader
`include "sbd_defs.vh"
`default_nettype none
module sbd_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC[5] = '{16, 108, 13, 24, 32};
  // the 1200 and 3906 syncs go out at their own rate, so the default-rate receiver sees a stretched start bit
  localparam int SCYC[5] = '{16, 108, 16, 16, 32};
  localparam logic [7:0] SYNC[5] = '{`SBD_SYNC_FAST, `SBD_SYNC_FAST, `SBD_SYNC_9600,
                                     `SBD_SYNC_5208, `SBD_SYNC_5208};
  logic        clock, rst_n, ce, moda, modb, ext_rates, boot_en_clr, emu_oe_n_pin;
  logic        rxd, txd, boot_rom_enable, jump_ram, jump_eeprom, loading, eprom_emul, emu_data_oe_n;
  logic [15:0] bus_addr;
  logic [7:0]  user_rom_data, boot_rom_data, emu_rom_data, read_data, ram_rd_data, emu_data_out;
  logic [8:0]  ram_rd_addr;
  logic [9:0]  load_count;
  logic [7:0]  bq[$];
  int          n_mismatch, check_count, seed, n;
  sbd_loader #(.BIT_CYC_7812(16), .BIT_CYC_1200(108), .BIT_CYC_9600(13), .BIT_CYC_5208(24),
    .BIT_CYC_3906(32)) sbd_loader_inst (
    .CLOCK(clock), .RST_N(rst_n), .CE(ce), .MODA(moda), .MODB(modb), .RXD(rxd),
    .EXT_RATES(ext_rates), .BOOT_EN_CLR(boot_en_clr), .BUS_ADDR(bus_addr),
    .USER_ROM_DATA(user_rom_data), .BOOT_ROM_DATA(boot_rom_data), .RAM_RD_ADDR(ram_rd_addr),
    .EMU_OE_N_PIN(emu_oe_n_pin), .EMU_ROM_DATA(emu_rom_data), .TXD(txd), .READ_DATA(read_data),
    .BOOT_ROM_ENABLE(boot_rom_enable), .RAM_RD_DATA(ram_rd_data), .JUMP_RAM(jump_ram),
    .JUMP_EEPROM(jump_eeprom), .LOADING(loading), .LOAD_COUNT(load_count),
    .EPROM_EMUL(eprom_emul), .EMU_DATA_OUT(emu_data_out), .EMU_DATA_OE_N(emu_data_oe_n));
  sbd_host_model host_inst (.clk(clock), .txd_in(txd), .rxd_out(rxd));
  function automatic logic [7:0] exp_rd(logic en, logic [15:0] a, logic [7:0] u, logic [7:0] b);
    return (en && a >= `SBD_BOOT_ROM_LO) ? b : u;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic ma, input logic mb);
    rst_n = 1'b0;
    moda = ma;
    modb = mb;
    repeat (6) @(posedge clock);
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      #2 emu_oe_n_pin = p[0];
      emu_rom_data = $random(seed);
      #1 check(eprom_emul, !ma && !mb, "emulation mode");
      check(emu_data_oe_n, !(!ma && !mb && !p[0]), "emulated data enable");
      check(emu_data_out, emu_rom_data, "emulated data");
    end
    @(posedge clock);
    #2 rst_n = 1'b1;
    repeat (30) @(posedge clock);
  endtask
  task automatic rd_check(input logic en);
    logic [15:0] a;
    for (int i = 0; i < 12; i++) begin
      a = (i < 2) ? 16'hBF3F + 16'(i) : $random(seed);
      #2 bus_addr = a;
      user_rom_data = $random(seed);
      boot_rom_data = $random(seed);
      @(posedge clock);
      #1 check(read_data, exp_rd(en, a, user_rom_data, boot_rom_data), "read mux");
      @(posedge clock);
    end
  endtask
  task automatic pulse_clr();
    #2 boot_en_clr = 1'b1;
    @(posedge clock);
    #2 boot_en_clr = 1'b0;
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    seed = 31;
    {ce, moda, modb, ext_rates, boot_en_clr, emu_oe_n_pin, rst_n} = 7'h79;
    {bus_addr, user_rom_data, boot_rom_data, emu_rom_data, ram_rd_addr} = '0;
    for (int k = 0; k < 5; k++) begin
      do_reset(1'b0, 1'b0);
      if (k == 0)
        repeat (3000) @(posedge clock);
      check(loading, 1'b0, "loading before sync");
      host_inst.send(SYNC[k], SCYC[k]);
      repeat (4) @(posedge clock);
      check(loading, 1'b1, "sync not taken");
      host_inst.cyc = CYC[k];
      host_inst.echo_q.delete();
      bq.delete();
      n = 1 + ($unsigned($random(seed)) % 6);
      for (int i = 0; i < n; i++)
        bq.push_back((i == 0) ? 8'h00 : (i == n - 1) ? 8'hFF : 8'($random(seed)));
      foreach (bq[i])
        host_inst.send(bq[i], CYC[k]);
      for (int t = 0; t < 20000 && jump_ram !== 1'b1; t++)
        @(posedge clock);
      #2 check(jump_ram, 1'b1, "download did not end");
      check(loading, 1'b0, "still loading");
      check(load_count, 16'(n), "byte count");
      check(host_inst.echo_q.size(), 16'(n), "echo count");
      for (int i = 0; i < n; i++) begin
        check(host_inst.echo_q[i], bq[i], "echo value");
        ram_rd_addr = 9'(i);
        @(posedge clock);
        #2 check(ram_rd_data, bq[i], "ram contents");
      end
    end
    check(boot_rom_enable, 1'b1, "boot enable reset");
    @(posedge clock);
    rd_check(1'b1);
    pulse_clr();
    check(boot_rom_enable, 1'b0, "boot enable clear");
    rd_check(1'b0);
    do_reset(1'b0, 1'b0);
    #2 ext_rates = 1'b0;
    host_inst.cyc = CYC[0];
    host_inst.send(`SBD_SYNC_9600, CYC[0]);
    repeat (8) @(posedge clock);
    #2 check(loading, 1'b0, "extended sync taken on plain variant");
    do_reset(1'b0, 1'b0);
    host_inst.send(`SBD_SKIP_CHAR, CYC[0]);
    repeat (8) @(posedge clock);
    #2 check({jump_eeprom, jump_ram, loading}, 16'h0004, "skip to eeprom");
    do_reset(1'b1, 1'b0);
    check(boot_rom_enable, 1'b0, "boot enable outside bootstrap");
    pulse_clr();
    rd_check(1'b0);
    summarize();
  end
endmodule
`default_nettype wire

//--- sbd_uart.v
// async serial receiver and double-buffered transmitter, 8N1
`default_nettype none
module sbd_uart (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [15:0] bit_cyc,
  input  wire        rxd_pin,
  input  wire [7:0]  tx_data,
  input  wire        tx_valid,
  output wire        tx_ready,
  output wire        txd,
  output reg  [7:0]  rx_data_ff,
  output reg         rx_valid_ff,
  output wire        rx_busy,
  output reg         bit_tick_ff
);
  reg [2:0]  rx_sync_ff;
  reg        rx_lvl_ff;
  reg        rx_act_ff;
  reg [3:0]  rx_idx_ff;
  reg [15:0] rx_cnt_ff;
  reg [7:0]  rx_sh_ff;
  reg [15:0] tick_cnt_ff;
  reg [7:0]  hold_ff;
  reg        hold_full_ff;
  reg [9:0]  tx_sh_ff;
  reg [3:0]  tx_left_ff;
  reg [15:0] tx_cnt_ff;

  assign rx_busy  = rx_act_ff;
  assign tx_ready = ~hold_full_ff;
  assign txd      = (tx_left_ff == 4'h0) ? 1'b1 : tx_sh_ff[0];

  // line level changes only once the two later stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_ff  <= 3'h7;
      rx_lvl_ff   <= 1'b1;
      rx_act_ff   <= 1'b0;
      rx_idx_ff   <= 4'h0;
      rx_cnt_ff   <= 16'h0000;
      rx_sh_ff    <= 8'h00;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else if (ce) begin
      rx_sync_ff  <= {rx_sync_ff[1:0], rxd_pin};
      rx_valid_ff <= 1'b0;
      if (rx_sync_ff[1] == rx_sync_ff[2])
        rx_lvl_ff <= rx_sync_ff[2];
      if (!rx_act_ff) begin
        if (rx_lvl_ff && rx_sync_ff[1] == rx_sync_ff[2] && !rx_sync_ff[2]) begin
          rx_act_ff <= 1'b1;
          rx_idx_ff <= 4'h0;
          rx_cnt_ff <= {1'b0, bit_cyc[15:1]};
        end
      end else if (rx_cnt_ff != 16'h0000) begin
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      end else begin
        rx_cnt_ff <= bit_cyc - 16'h0001;
        rx_idx_ff <= rx_idx_ff + 4'h1;
        if (rx_idx_ff == 4'h0 && rx_lvl_ff)
          rx_act_ff <= 1'b0;
        else if (rx_idx_ff == 4'h9) begin
          // a break delivers zero data, which the loader treats as the skip char while waiting for sync
          rx_act_ff   <= 1'b0;
          rx_data_ff  <= rx_sh_ff;
          rx_valid_ff <= 1'b1;
        end else if (rx_idx_ff != 4'h0)
          rx_sh_ff <= {rx_lvl_ff, rx_sh_ff[7:1]};
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
      bit_tick_ff <= 1'b0;
    end else if (ce) begin
      bit_tick_ff <= (tick_cnt_ff == 16'h0000);
      tick_cnt_ff <= (tick_cnt_ff == 16'h0000) ? bit_cyc - 16'h0001 : tick_cnt_ff - 16'h0001;
    end
  end

  // holding register plus shifter: two characters may be in flight
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff      <= 8'h00;
      hold_full_ff <= 1'b0;
      tx_sh_ff     <= 10'h3FF;
      tx_left_ff   <= 4'h0;
      tx_cnt_ff    <= 16'h0000;
    end else if (ce) begin
      if (tx_valid && !hold_full_ff) begin
        hold_ff      <= tx_data;
        hold_full_ff <= 1'b1;
      end
      if (tx_left_ff == 4'h0) begin
        if (hold_full_ff) begin
          tx_sh_ff     <= {1'b1, hold_ff, 1'b0};
          tx_left_ff   <= 4'hA;
          tx_cnt_ff    <= bit_cyc - 16'h0001;
          hold_full_ff <= 1'b0;
        end
      end else if (tx_cnt_ff != 16'h0000) begin
        tx_cnt_ff <= tx_cnt_ff - 16'h0001;
      end else begin
        tx_cnt_ff  <= bit_cyc - 16'h0001;
        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
